/* File: dtc_defs.svh */
// Register offsets, field positions, reset values and timing counts for the dual timer block
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
// Printed offsets are not all multiples of four: these are indexes, byte address is index*4
`define DTC_IDX_RUN_FLAG 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_A_LOW 8'h8A
`define DTC_IDX_B_LOW 8'h8B
`define DTC_IDX_A_HIGH 8'h8C
`define DTC_IDX_B_HIGH 8'h8D
`define DTC_IDX_PRESCALE 8'h8E
`define DTC_IDX_IRQ_EN 8'hA8
`define DTC_IDX_IRQ_PRIO 8'hB8
`define DTC_IDX_IRQ_ACK 8'hF0
// Run/flag register fields
`define DTC_B_OVF_BIT 7
`define DTC_B_RUN_BIT 6
`define DTC_A_OVF_BIT 5
`define DTC_A_RUN_BIT 4
// Mode register fields
`define DTC_B_SRC_BIT 6
`define DTC_B_MODE_LSB 4
`define DTC_A_SRC_BIT 2
`define DTC_A_MODE_LSB 0
`define DTC_MODE_WMASK 8'h77
// Prescale fields
`define DTC_B_BYP_BIT 1
`define DTC_A_BYP_BIT 0
`define DTC_PRESCALE_WMASK 8'h07
// Interrupt enable / priority fields
`define DTC_GIE_BIT 7
`define DTC_B_IE_BIT 3
`define DTC_A_IE_BIT 1
`define DTC_B_IP_BIT 3
`define DTC_A_IP_BIT 1
`define DTC_IE_WMASK 8'hEF
`define DTC_IP_WMASK 8'h7F
`define DTC_RUN_FLAG_WMASK 8'hFA
// Reset values
`define DTC_RST_BYTE 8'h00
// Prescale divide ratio
`define DTC_PRESCALE_DIV 12
`endif

/* File: dtc_pkg.sv */
// Types shared by the dual timer block
package dtc_pkg;
   typedef enum logic [1:0] {
      DTC_MODE_13BIT,
      DTC_MODE_16BIT,
      DTC_MODE_RELOAD8,
      DTC_MODE_SPLIT
   } dtc_mode_t;
endpackage : dtc_pkg

/* File: dtc_tick_if.sv */
// Count-enable ticks passed from the tick generator to the timer core
interface dtc_tick_if;
   logic sys_tick;
   logic div_tick;
   logic a_pin_fall;
   logic b_pin_fall;
   modport gen (output sys_tick, output div_tick, output a_pin_fall, output b_pin_fall);
   modport use_side (input sys_tick, input div_tick, input a_pin_fall, input b_pin_fall);
endinterface : dtc_tick_if

/* File: dtc_tick_gen.sv */
// Divide-by-twelve prescaler and falling-edge detectors for the count pins
`include "dtc_defs.svh"
module dtc_tick_gen #(
   parameter int DIV = `DTC_PRESCALE_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic a_count_pin_i,
   input wire logic b_count_pin_i,
   dtc_tick_if.gen tick
);
   initial if (DIV < 2 || DIV > 256) $error("dtc_tick_gen: DIV out of range");

   typedef struct packed {
      logic [7:0] div_cnt;
      logic a_pin;
      logic b_pin;
   } dtc_tick_state_t;

   dtc_tick_state_t st_ff;
   dtc_tick_state_t nxt_st;

   // Divider wraps at DIV-1; pins sampled once for edge compare
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.div_cnt = (st_ff.div_cnt == 8'(DIV - 1)) ? 8'h00 : st_ff.div_cnt + 8'h01;
      nxt_st.a_pin = a_count_pin_i;
      nxt_st.b_pin = b_count_pin_i;
   end

   // Pins reset high, so a pin already low at release counts as one falling edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_ff <= '{div_cnt: 8'h00, a_pin: 1'b1, b_pin: 1'b1};
      else
         st_ff <= nxt_st;
   end

   assign tick.sys_tick = 1'b1;
   assign tick.div_tick = (st_ff.div_cnt == 8'(DIV - 1));
   assign tick.a_pin_fall = st_ff.a_pin & ~a_count_pin_i;
   assign tick.b_pin_fall = st_ff.b_pin & ~b_count_pin_i;
endmodule : dtc_tick_gen

/* File: dtc_reg_slave.sv */
// Classic Wishbone byte-register slave front end: decode and one-cycle ack
module dtc_reg_slave (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic sel0_i,
   input wire logic [9:0] adr_i,
   output logic ack_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] idx_o
);
   typedef struct packed {
      logic ack;
   } dtc_slv_state_t;

   dtc_slv_state_t st_ff;
   dtc_slv_state_t nxt_st;

   // Ack one cycle after request, dropped the cycle after
   always_comb
   begin
      nxt_st.ack = cyc_i & stb_i & ~st_ff.ack;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_ff <= '{ack: 1'b0};
      else
         st_ff <= nxt_st;
   end

   assign ack_o = st_ff.ack;
   // Write lands only on the acking edge, and only with lane 0 selected
   assign wr_o = cyc_i & stb_i & st_ff.ack & we_i & sel0_i;
   assign rd_o = cyc_i & stb_i & ~st_ff.ack & ~we_i;
   assign idx_o = adr_i[9:2];
endmodule : dtc_reg_slave

/* File: dtc_timer_top.sv */
// Dual 16-bit timer/counter with mode, prescale, enable and priority registers
//
// Function
// RULE1 - Overflow flag set on overflow, cleared on vector
// RULE2 - Timer counts only while its run bit set
// RULE3 - Timer B source: system clock or pin
// RULE4 - Timer A source: system clock or pin
// RULE5 - Timer B modes 13-bit and 16-bit
// RULE6 - Timer B mode 2 reloads low from high
// RULE7 - Timer B mode 3 holds count stopped
// RULE8 - Timer A modes 13-bit and 16-bit
// RULE9 - Timer A mode 2 reloads low from high
// RULE10 - Split mode low byte uses timer A controls
// RULE11 - Split high byte: timer only, run B
// RULE12 - Mode bits 0-2 timer A, 4-6 timer B
// RULE13 - Prescale bit 1 picks timer B clock rate
// RULE14 - Prescale bit 0 picks timer A clock rate
// RULE15 - Enable bit 3 gates timer B interrupt
// RULE16 - Enable bit 1 gates timer A interrupt
// RULE17 - Priority bits 3 and 1 set priority
// RULE18 - Counter mode counts pin falling edges
// RULE19 - Setting run bit keeps the count
// RULE20 - Split high overflow sets B flag, stops B
// RULE21 - Request needs flag, enable and global enable
// RULE22 - Overflow on wrap, same edge as increment
//
// Implementation choice: the Wishbone slave port.
`include "dtc_defs.svh"
module dtc_timer_top #(
   parameter int PRESCALE_DIV = `DTC_PRESCALE_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [9:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic timer_a_pin_i,
   input wire logic timer_b_pin_i,
   input wire logic timer_a_vector_i,
   input wire logic timer_b_vector_i,
   output logic timer_a_irq_o,
   output logic timer_b_irq_o,
   output logic timer_a_irq_high_o,
   output logic timer_b_irq_high_o
);
   initial if (PRESCALE_DIV != `DTC_PRESCALE_DIV) $error("dtc_timer_top: prescale must divide by twelve");

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [7:0] run_flag;
      logic [7:0] mode;
      logic [7:0] prescale;
      logic [7:0] irq_en;
      logic [7:0] irq_prio;
      logic [7:0] a_low;
      logic [7:0] a_high;
      logic [7:0] b_low;
      logic [7:0] b_high;
      logic [7:0] rd_data;
   } dtc_top_state_t;

   dtc_top_state_t st_ff;
   dtc_top_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   dtc_tick_if tick ();

   dtc_tick_gen #(
      .DIV(PRESCALE_DIV)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .a_count_pin_i(timer_a_pin_i),
      .b_count_pin_i(timer_b_pin_i),
      .tick(tick.gen)
   );

   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_idx;

   dtc_reg_slave u_slave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .sel0_i(sel_i[0]),
      .adr_i(adr_i),
      .ack_o(ack_o),
      .wr_o(reg_wr),
      .rd_o(reg_rd),
      .idx_o(reg_idx)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Masked write: reserved bits stay zero
   function automatic logic [7:0] wr_masked(input logic [7:0] data, input logic [7:0] mask);
      wr_masked = data & mask;
   endfunction : wr_masked

   // Pick count enable from source, prescale and run bit
   function automatic logic count_en(input logic run, input logic src_pin, input logic bypass,
                                     input logic pin_fall, input logic sys_t, input logic div_t);
      logic tmr;
      tmr = bypass ? sys_t : div_t;
      count_en = run & (src_pin ? pin_fall : tmr);
   endfunction : count_en

   ////////////////////////////////////////////////////////////////////////////
   // Decoded controls
   dtc_pkg::dtc_mode_t a_mode;
   dtc_pkg::dtc_mode_t b_mode;
   logic a_en;
   logic b_en;
   logic split_high_en;
   logic a_ovf;
   logic b_ovf;

   // Mode fields split per timer [RULE12]
   assign a_mode = dtc_pkg::dtc_mode_t'(st_ff.mode[`DTC_A_MODE_LSB +: 2]); // [RULE12]
   assign b_mode = dtc_pkg::dtc_mode_t'(st_ff.mode[`DTC_B_MODE_LSB +: 2]); // [RULE12]

   // Count enables; counter-mode uses pin falling edges [RULE18]
   assign a_en = count_en(st_ff.run_flag[`DTC_A_RUN_BIT], st_ff.mode[`DTC_A_SRC_BIT],
                          st_ff.prescale[`DTC_A_BYP_BIT], tick.a_pin_fall,
                          tick.sys_tick, tick.div_tick); // [RULE2] [RULE4] [RULE14] [RULE18]
   assign b_en = count_en(st_ff.run_flag[`DTC_B_RUN_BIT], st_ff.mode[`DTC_B_SRC_BIT],
                          st_ff.prescale[`DTC_B_BYP_BIT], tick.b_pin_fall,
                          tick.sys_tick, tick.div_tick); // [RULE2] [RULE3] [RULE13] [RULE18]
   // Split high byte: always timer source, run bit of B, prescale of A
   assign split_high_en = count_en(st_ff.run_flag[`DTC_B_RUN_BIT], 1'b0,
                                   st_ff.prescale[`DTC_A_BYP_BIT], 1'b0,
                                   tick.sys_tick, tick.div_tick); // [RULE11]

   ////////////////////////////////////////////////////////////////////////////
   // Next state: counting, overflow flags, register writes
   always_comb
   begin
      logic [7:0] wdat;
      logic a_hi_ovf;
      wdat = dat_i[7:0];
      a_hi_ovf = 1'b0;
      nxt_st = st_ff;
      a_ovf = 1'b0;
      b_ovf = 1'b0;

      // Software writes first; counting and flag sets below override
      if (reg_wr)
      begin
         unique case (reg_idx)
            `DTC_IDX_RUN_FLAG: nxt_st.run_flag = wr_masked(wdat, `DTC_RUN_FLAG_WMASK);
            `DTC_IDX_MODE: nxt_st.mode = wr_masked(wdat, `DTC_MODE_WMASK); // [RULE12]
            `DTC_IDX_PRESCALE: nxt_st.prescale = wr_masked(wdat, `DTC_PRESCALE_WMASK);
            `DTC_IDX_IRQ_EN: nxt_st.irq_en = wr_masked(wdat, `DTC_IE_WMASK);
            `DTC_IDX_IRQ_PRIO: nxt_st.irq_prio = wr_masked(wdat, `DTC_IP_WMASK);
            `DTC_IDX_A_LOW: nxt_st.a_low = wdat;
            `DTC_IDX_A_HIGH: nxt_st.a_high = wdat;
            `DTC_IDX_B_LOW: nxt_st.b_low = wdat;
            `DTC_IDX_B_HIGH: nxt_st.b_high = wdat;
            default: ;
         endcase
      end

      // Vector acknowledge clears flags; a set below still wins [RULE1]
      if (timer_a_vector_i)
         nxt_st.run_flag[`DTC_A_OVF_BIT] = 1'b0; // [RULE1]
      if (timer_b_vector_i)
         nxt_st.run_flag[`DTC_B_OVF_BIT] = 1'b0; // [RULE1]

      // Timer A; counts keep their value across run changes [RULE19]
      if (a_en)
      begin
         unique case (a_mode)
            dtc_pkg::DTC_MODE_13BIT:
            begin
               // Low 5 bits count, top three bits left alone [RULE8]
               nxt_st.a_low[4:0] = st_ff.a_low[4:0] + 5'h01;
               if (st_ff.a_low[4:0] == 5'h1F)
               begin
                  nxt_st.a_high = st_ff.a_high + 8'h01;
                  a_ovf = (st_ff.a_high == 8'hFF); // [RULE22]
               end
            end
            dtc_pkg::DTC_MODE_16BIT:
            begin
               {nxt_st.a_high, nxt_st.a_low} = {st_ff.a_high, st_ff.a_low} + 16'h0001; // [RULE8]
               a_ovf = ({st_ff.a_high, st_ff.a_low} == 16'hFFFF); // [RULE22]
            end
            dtc_pkg::DTC_MODE_RELOAD8:
            begin
               a_ovf = (st_ff.a_low == 8'hFF); // [RULE22]
               nxt_st.a_low = a_ovf ? st_ff.a_high : st_ff.a_low + 8'h01; // [RULE9]
            end
            dtc_pkg::DTC_MODE_SPLIT:
            begin
               // Low byte alone with A controls [RULE10]
               nxt_st.a_low = st_ff.a_low + 8'h01; // [RULE10]
               a_ovf = (st_ff.a_low == 8'hFF); // [RULE10] [RULE22]
            end
         endcase
      end

      // Split high byte runs as a timer with B's run bit [RULE11]
      if (a_mode == dtc_pkg::DTC_MODE_SPLIT && split_high_en)
      begin
         nxt_st.a_high = st_ff.a_high + 8'h01; // [RULE11]
         a_hi_ovf = (st_ff.a_high == 8'hFF); // [RULE20]
      end

      // Timer B stops in its mode 3 and while A is split [RULE7] [RULE20]
      if (b_en && b_mode != dtc_pkg::DTC_MODE_SPLIT && a_mode != dtc_pkg::DTC_MODE_SPLIT)
      begin
         unique case (b_mode)
            dtc_pkg::DTC_MODE_13BIT:
            begin
               nxt_st.b_low[4:0] = st_ff.b_low[4:0] + 5'h01; // [RULE5]
               if (st_ff.b_low[4:0] == 5'h1F)
               begin
                  nxt_st.b_high = st_ff.b_high + 8'h01;
                  b_ovf = (st_ff.b_high == 8'hFF); // [RULE22]
               end
            end
            dtc_pkg::DTC_MODE_16BIT:
            begin
               {nxt_st.b_high, nxt_st.b_low} = {st_ff.b_high, st_ff.b_low} + 16'h0001; // [RULE5]
               b_ovf = ({st_ff.b_high, st_ff.b_low} == 16'hFFFF); // [RULE22]
            end
            dtc_pkg::DTC_MODE_RELOAD8:
            begin
               b_ovf = (st_ff.b_low == 8'hFF); // [RULE22]
               nxt_st.b_low = b_ovf ? st_ff.b_high : st_ff.b_low + 8'h01; // [RULE6]
            end
            dtc_pkg::DTC_MODE_SPLIT: ; // [RULE7]
         endcase
      end

      // Flag set beats a same-cycle clear or write [RULE1]
      if (a_ovf)
         nxt_st.run_flag[`DTC_A_OVF_BIT] = 1'b1; // [RULE1]
      if (b_ovf || a_hi_ovf)
         nxt_st.run_flag[`DTC_B_OVF_BIT] = 1'b1; // [RULE1] [RULE20]

      // Read data captured on request edge, held till ack
      if (reg_rd)
      begin
         unique case (reg_idx)
            `DTC_IDX_RUN_FLAG: nxt_st.rd_data = st_ff.run_flag;
            `DTC_IDX_MODE: nxt_st.rd_data = st_ff.mode;
            `DTC_IDX_PRESCALE: nxt_st.rd_data = st_ff.prescale;
            `DTC_IDX_IRQ_EN: nxt_st.rd_data = st_ff.irq_en;
            `DTC_IDX_IRQ_PRIO: nxt_st.rd_data = st_ff.irq_prio;
            `DTC_IDX_A_LOW: nxt_st.rd_data = st_ff.a_low;
            `DTC_IDX_A_HIGH: nxt_st.rd_data = st_ff.a_high;
            `DTC_IDX_B_LOW: nxt_st.rd_data = st_ff.b_low;
            `DTC_IDX_B_HIGH: nxt_st.rd_data = st_ff.b_high;
            default: nxt_st.rd_data = `DTC_RST_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_ff <= '{default: `DTC_RST_BYTE};
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign dat_o = {24'h000000, st_ff.rd_data};

   // Requests gated by flag, own enable and global enable [RULE21]
   assign timer_a_irq_o = st_ff.run_flag[`DTC_A_OVF_BIT] & st_ff.irq_en[`DTC_A_IE_BIT]
                          & st_ff.irq_en[`DTC_GIE_BIT]; // [RULE16] [RULE21]
   assign timer_b_irq_o = st_ff.run_flag[`DTC_B_OVF_BIT] & st_ff.irq_en[`DTC_B_IE_BIT]
                          & st_ff.irq_en[`DTC_GIE_BIT]; // [RULE15] [RULE21]
   // Priority level straight from the priority register [RULE17]
   assign timer_a_irq_high_o = st_ff.irq_prio[`DTC_A_IP_BIT]; // [RULE17]
   assign timer_b_irq_high_o = st_ff.irq_prio[`DTC_B_IP_BIT]; // [RULE17]
endmodule : dtc_timer_top

/* File: dtc_timer_properties.sv */
// Bus handshake and interrupt-output properties of the dual timer block
`include "dtc_defs.svh"
module dtc_timer_checker #(
   parameter int PRESCALE_DIV = `DTC_PRESCALE_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [9:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic timer_a_irq_o,
   input wire logic timer_b_irq_o,
   input wire logic timer_a_irq_high_o,
   input wire logic timer_b_irq_high_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Request taken, and a write landing at its ack edge
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_wr(idx);
      ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i[9:2] == idx;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // Handshake: one answer per request, one cycle long
   AST_ACK_ANSWER: assert property (s_req |=> ack_o)
      else $error("request not answered next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   AST_READ_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   // Reserved mode bits must never read back set
   AST_MODE_RESERVED: assert property ((ack_o && !we_i && adr_i[9:2] == `DTC_IDX_MODE) |-> !dat_o[7] && !dat_o[3])
      else $error("reserved mode bit read as one");
   // Clearing an enable or the global enable silences the request at once
   AST_A_IRQ_GATE: assert property ((s_wr(`DTC_IDX_IRQ_EN) ##0 (!dat_i[1] || !dat_i[7])) |=> !timer_a_irq_o)
      else $error("timer a request with enable cleared");
   AST_B_IRQ_GATE: assert property ((s_wr(`DTC_IDX_IRQ_EN) ##0 (!dat_i[3] || !dat_i[7])) |=> !timer_b_irq_o)
      else $error("timer b request with enable cleared");
   // Priority outputs follow their register bits
   AST_A_PRIO: assert property (s_wr(`DTC_IDX_IRQ_PRIO) |=> timer_a_irq_high_o == $past(dat_i[1]))
      else $error("timer a priority wrong");
   AST_B_PRIO: assert property (s_wr(`DTC_IDX_IRQ_PRIO) |=> timer_b_irq_high_o == $past(dat_i[3]))
      else $error("timer b priority wrong");
   AST_PRIO_HOLD: assert property (!$stable({timer_a_irq_high_o, timer_b_irq_high_o}) |-> $past(ack_o && we_i && sel_i[0] && adr_i[9:2] == `DTC_IDX_IRQ_PRIO))
      else $error("priority changed without a write");
endmodule : dtc_timer_checker

bind dtc_timer_top dtc_timer_checker #(.PRESCALE_DIV(PRESCALE_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .timer_a_irq_o(timer_a_irq_o), .timer_b_irq_o(timer_b_irq_o),
   .timer_a_irq_high_o(timer_a_irq_high_o), .timer_b_irq_high_o(timer_b_irq_high_o));

/* File: tb_top.sv */
// Self-checking bench for the dual timer block
`include "dtc_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int t; logic [7:0] mv, pv, li, hx, lv, hv; int lo, hi;} dtc_case_t;
   logic clk_i, rst_i, cyc, stb, we, ack;
   logic [9:0] adr;
   logic [31:0] dat_w, dat_r;
   logic [1:0] pin, vec;
   wire [1:0] irq, hi;
   logic [7:0] rd;
   int bad_count, checks, n;
   logic [7:0] ridx [9] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hA8, 8'hB8};
   logic [7:0] widx [5] = '{8'h89, 8'h8E, 8'hA8, 8'hB8, 8'h90};
   logic [7:0] wmsk [5] = '{8'h77, 8'h07, 8'hEF, 8'h7F, 8'h00};
   // Timer, mode, prescale, preload places and values, overflow delay window
   dtc_case_t tbl [12] = '{
      '{0, 8'h00, 8'h01, 8'h8A, 8'h8C, 8'h1E, 8'hFF, 1, 6}, // 13-bit
      '{0, 8'h01, 8'h01, 8'h8A, 8'h8C, 8'h1E, 8'hFF, 224, 232}, // 16-bit
      '{0, 8'h00, 8'h00, 8'h8A, 8'h8C, 8'h1E, 8'hFF, 12, 30}, // divided
      '{0, 8'h04, 8'h01, 8'h8A, 8'h8C, 8'h1E, 8'hFF, 12, 20}, // pin
      '{0, 8'h02, 8'h01, 8'h8A, 8'h8C, 8'hFE, 8'hF0, 1, 6}, // reload
      '{1, 8'h00, 8'h02, 8'h8B, 8'h8D, 8'h1E, 8'hFF, 1, 6}, // 13-bit
      '{1, 8'h10, 8'h02, 8'h8B, 8'h8D, 8'h1E, 8'hFF, 224, 232}, // 16-bit
      '{1, 8'h00, 8'h00, 8'h8B, 8'h8D, 8'h1E, 8'hFF, 12, 30}, // divided
      '{1, 8'h40, 8'h02, 8'h8B, 8'h8D, 8'h1E, 8'hFF, 12, 20}, // pin
      '{1, 8'h20, 8'h02, 8'h8B, 8'h8D, 8'hFE, 8'hF0, 1, 6}, // reload
      '{1, 8'h30, 8'h02, 8'h8B, 8'h8D, 8'hFE, 8'hFF, 400, 400}, // held
      '{1, 8'h03, 8'h01, 8'h8C, 8'h8C, 8'hFE, 8'hFE, 1, 6}}; // split
   ////////////////////////////////////////////////////////////////////////////////
   dtc_timer_top #(.PRESCALE_DIV(12)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .sel_i(4'h1), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .timer_a_pin_i(pin[0]), .timer_b_pin_i(pin[1]), .timer_a_vector_i(vec[0]), .timer_b_vector_i(vec[1]),
      .timer_a_irq_o(irq[0]), .timer_b_irq_o(irq[1]), .timer_a_irq_high_o(hi[0]), .timer_b_irq_high_o(hi[1]));
   // Clock
   initial
   begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   // One classic cycle; waits for ack, no fixed latency assumed
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int k;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {idx, 2'h0};
      dat_w <= {24'h000000, wd};
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'h1 && k < 20);
      rd = dat_r[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      if (k >= 20)
         chk8("ack", 8'h01, 8'h00);
      #1;
   endtask : bus
   task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
      bus(1'h0, idx, 8'h00);
      chk8(nm, e, rd);
   endtask : rc
   // Preload, run until overflow, then flag, gating and vector checks
   task automatic run_case(input dtc_case_t c);
      logic [7:0] fl, en;
      fl = c.t ? 8'h80 : 8'h20;
      en = c.t ? 8'h08 : 8'h02;
      pin = 2'h3;
      bus(1'h1, `DTC_IDX_RUN_FLAG, 8'h00);
      bus(1'h1, `DTC_IDX_MODE, c.mv);
      bus(1'h1, `DTC_IDX_PRESCALE, c.pv);
      bus(1'h1, `DTC_IDX_IRQ_EN, 8'h80 | en);
      bus(1'h1, c.hx, c.hv);
      bus(1'h1, c.li, c.lv);
      rc("count while stopped", c.li, c.lv);
      bus(1'h1, `DTC_IDX_RUN_FLAG, c.t ? 8'h40 : 8'h10);
      n = 0;
      while (irq[c.t] !== 1'h1 && n < 400)
      begin
         @(posedge clk_i);
         n++;
         pin[c.t] <= c.mv[c.t ? 6 : 2] ? ~n[2] : 1'h1;
         pin[1 - c.t] <= 1'($urandom);
      end
      chk8("overflow delay", 8'h01, {7'h00, n >= c.lo && n <= c.hi});
      // Flag read before the stop write, so only hardware can have set it
      if (n < 400)
         rc("flag", `DTC_IDX_RUN_FLAG, fl | (c.t ? 8'h40 : 8'h10));
      bus(1'h1, `DTC_IDX_RUN_FLAG, n == 400 ? 8'h00 : fl);
      if (n == 400)
         rc("held count", c.li, c.lv);
      else
      begin
         if ((c.t ? c.mv[5:4] : c.mv[1:0]) == 2'h2)
         begin
            rc("reload value", c.hx, c.hv);
            bus(1'h0, c.li, 8'h00);
            chk8("reloaded low", 8'h01, {7'h00, rd >= c.hv});
         end
         bus(1'h1, `DTC_IDX_IRQ_EN, en);
         chk8("irq no global", 8'h00, {6'h00, irq});
         bus(1'h1, `DTC_IDX_IRQ_EN, 8'h80);
         chk8("irq no enable", 8'h00, {6'h00, irq});
         bus(1'h1, `DTC_IDX_IRQ_EN, 8'h80 | en);
         chk8("irq enabled", c.t ? 8'h02 : 8'h01, {6'h00, irq});
         @(posedge clk_i);
         vec[c.t] <= 1'h1;
         @(posedge clk_i);
         vec[c.t] <= 1'h0;
         #1;
         chk8("irq after vector", 8'h00, {6'h00, irq});
      end
   endtask : run_case
   task automatic end_sim();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [7:0] v;
      int k;
      {rst_i, cyc, stb, we, pin, vec} = 8'h8C;
      adr = 10'h000;
      dat_w = 32'h00000000;
      void'($urandom(61));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (ridx[i])
         rc("reset value", ridx[i], 8'h00);
      // Random writes, reserved bits and an unmapped place included
      for (int i = 0; i < 40; i++)
      begin
         k = i % 5;
         v = 8'($urandom);
         bus(1'h1, widx[k], v);
         rc("masked readback", widx[k], v & wmsk[k]);
         if (k == 3)
            chk8("priority outputs", {6'h00, v[3], v[1]}, {6'h00, hi});
      end
      foreach (tbl[i])
         run_case(tbl[i]);
      // Timer B ran with its run bit set during split, its count must not move
      rc("b count in split", `DTC_IDX_B_LOW, 8'hFE);
      end_sim();
   end
   // Watchdog
   initial
   begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule : tb_top
